// [verilog/frame_timer_regs.svh]
// command codes, field positions, reset values and rates of the frame timer
`ifndef FRAME_TIMER_REGS_SVH
`define FRAME_TIMER_REGS_SVH

`define FT_CODE_CTRL 8'h01
`define FT_CODE_CMD 8'h02
`define FT_CODE_ISTAT 8'h03
`define FT_CODE_IMASK 8'h04
`define FT_CODE_INTERVAL 8'h0D
`define FT_CODE_REMAIN 8'h0E
`define FT_CODE_NUMBER 8'h0F
`define FT_WRITE_OFS 8'h80

`define FT_TOGGLE_POS 31
`define FT_BUDGET_LSB 16
`define FT_BUDGET_MSB 30
`define FT_COUNT_MSB 13
`define FT_NUMBER_MSB 15
`define FT_RESET_POS 0
`define FT_RUN_POS 0
`define FT_IRQ_SOF_POS 0
`define FT_IRQ_WRAP_POS 1
`define FT_IRQ_W 2

`define FT_INTERVAL_NOMINAL 14'h2EDF
`define FT_BUDGET_RESET 15'h0000
`define FT_REMAIN_RESET 14'h0000
`define FT_NUMBER_RESET 16'h0000
`define FT_NUMBER_MAX 16'hFFFF

`define FT_CLK_HZ 40000000
`define FT_BIT_HZ 12000000

`endif

// [verilog/frame_timer_pkg.sv]
// types shared by the frame timer modules
`include "frame_timer_regs.svh"

package frame_timer_pkg;

    typedef enum logic [1:0] {
        PH_IDLE = 2'h0,
        PH_SOF = 2'h1,
        PH_COMM = 2'h3,
        PH_FLAG = 2'h2
    } phase_t;

    typedef struct packed {
        logic [13:0] interval;
        logic [14:0] budget;
        logic interval_toggle;
        logic [13:0] remaining;
        logic remaining_toggle;
        logic [15:0] frame_num;
        logic [14:0] packet_count;
        logic run;
        logic run_prev;
        phase_t phase;
        logic sof;
        logic comm_wr;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic [31:0] rdata;
    } timer_state_t;

    typedef struct packed {
        logic [31:0] acc;
        logic tick;
    } tick_state_t;

endpackage

// [verilog/bit_tick_gen.sv]
// fractional divider giving a one-cycle bit-time enable
`timescale 1ns/10ps
`default_nettype none
`include "frame_timer_regs.svh"

module bit_tick_gen #(
    parameter int unsigned CLK_HZ = `FT_CLK_HZ,
    parameter int unsigned BIT_HZ = `FT_BIT_HZ
) (
    input wire logic ref_clk,
    input wire logic rst,
    output logic tick
);

    frame_timer_pkg::tick_state_t st_reg;
    frame_timer_pkg::tick_state_t st_next;
    logic [32:0] sum;

    // phase accumulator: average tick rate is exactly BIT_HZ
    always_comb
    begin
        st_next = st_reg;
        sum = {1'b0, st_reg.acc} + 33'(BIT_HZ);
        if (sum >= 33'(CLK_HZ))
        begin
            st_next.acc = 32'(sum - 33'(CLK_HZ));
            st_next.tick = 1'b1;
        end
        else
        begin
            st_next.acc = sum[31:0];
            st_next.tick = 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign tick = st_reg.tick;

endmodule

`default_nettype wire

// [verilog/usb_host_frame_timer.sv]
// frame interval, frame remaining and frame number logic of the host controller
`timescale 1ns/10ps
`default_nettype none
`include "frame_timer_regs.svh"

module usb_host_frame_timer #(
    parameter int unsigned CLK_HZ = `FT_CLK_HZ,
    parameter int unsigned BIT_HZ = `FT_BIT_HZ
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    input wire logic packet_bit,
    output logic sof_pulse,
    output logic comm_wr,
    output logic [15:0] comm_data,
    output logic ed_fetch_ok,
    output logic operational_state,
    output logic [13:0] remaining_count,
    output logic [15:0] frame_number,
    output logic [14:0] packet_count
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic wr_hit(input logic wr, input logic [7:0] a,
                                    input logic [7:0] code);
        wr_hit = wr && (a == (code | `FT_WRITE_OFS));
    endfunction

    function automatic logic rd_hit(input logic rd, input logic [7:0] a,
                                    input logic [7:0] code);
        rd_hit = rd && (a == code);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bit-time enable

    logic tick;

    bit_tick_gen #(
        .CLK_HZ(CLK_HZ),
        .BIT_HZ(BIT_HZ)
    ) u_tick (
        .ref_clk(ref_clk),
        .rst(rst),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state

    frame_timer_pkg::timer_state_t st_reg;
    frame_timer_pkg::timer_state_t st_next;

    logic wr_ctrl;
    logic wr_cmd;
    logic wr_mask;
    logic wr_interval;
    logic wr_remain;
    logic rd_istat;
    logic entry;
    logic reload;
    logic [1:0] events;

    assign wr_ctrl = wr_hit(reg_wr, reg_addr, `FT_CODE_CTRL);
    assign wr_cmd = wr_hit(reg_wr, reg_addr, `FT_CODE_CMD);
    assign wr_mask = wr_hit(reg_wr, reg_addr, `FT_CODE_IMASK);
    assign wr_interval = wr_hit(reg_wr, reg_addr, `FT_CODE_INTERVAL);
    assign wr_remain = wr_hit(reg_wr, reg_addr, `FT_CODE_REMAIN);
    assign rd_istat = rd_hit(reg_rd, reg_addr, `FT_CODE_ISTAT);

    // entry into the operational state is seen in the first cycle that run is set
    assign entry = st_reg.run && !st_reg.run_prev;
    // a frame boundary: counter at zero on a bit tick while running
    assign reload = st_reg.run && !entry && tick && (st_reg.remaining == '0);

    always_comb
    begin
        st_next = st_reg;
        events = '0;
        st_next.run_prev = st_reg.run;
        st_next.sof = 1'b0;
        st_next.comm_wr = 1'b0;

        // counters, held when not operational
        if (entry)
        begin
            st_next.remaining = st_reg.interval;
            st_next.frame_num = st_reg.frame_num + 16'h0001;
            st_next.packet_count = st_reg.budget;
            st_next.sof = 1'b1;
            st_next.phase = frame_timer_pkg::PH_SOF;
            if (st_reg.frame_num == `FT_NUMBER_MAX)
                events[`FT_IRQ_WRAP_POS] = 1'b1;
        end
        else if (reload)
        begin
            st_next.remaining = st_reg.interval;
            st_next.remaining_toggle = st_reg.interval_toggle;
            st_next.frame_num = st_reg.frame_num + 16'h0001;
            st_next.packet_count = st_reg.budget;
            st_next.sof = 1'b1;
            st_next.phase = frame_timer_pkg::PH_SOF;
            if (st_reg.frame_num == `FT_NUMBER_MAX)
                events[`FT_IRQ_WRAP_POS] = 1'b1;
        end
        else if (st_reg.run && tick)
        begin
            st_next.remaining = st_reg.remaining - 14'h0001;
            if (packet_bit && (st_reg.packet_count != '0))
                st_next.packet_count = st_reg.packet_count - 15'h0001;
        end

        // frame start sequence: number to shared area, then start flag
        case (st_reg.phase)
            frame_timer_pkg::PH_IDLE:
            begin
            end
            frame_timer_pkg::PH_SOF:
            begin
                if (!(entry || reload))
                begin
                    st_next.comm_wr = 1'b1;
                    st_next.phase = frame_timer_pkg::PH_COMM;
                end
            end
            frame_timer_pkg::PH_COMM:
            begin
                events[`FT_IRQ_SOF_POS] = 1'b1;
                if (!(entry || reload))
                    st_next.phase = frame_timer_pkg::PH_FLAG;
            end
            frame_timer_pkg::PH_FLAG:
            begin
                if (!(entry || reload))
                    st_next.phase = frame_timer_pkg::PH_IDLE;
            end
            default:
            begin
                st_next.phase = frame_timer_pkg::PH_IDLE;
            end
        endcase

        // register writes
        if (wr_ctrl)
            st_next.run = reg_wdata[`FT_RUN_POS];
        if (wr_mask)
            st_next.irq_mask = reg_wdata[`FT_IRQ_W-1:0];
        if (wr_interval)
        begin
            st_next.interval_toggle = reg_wdata[`FT_TOGGLE_POS];
            st_next.budget = reg_wdata[`FT_BUDGET_MSB:`FT_BUDGET_LSB];
            st_next.interval = reg_wdata[`FT_COUNT_MSB:0];
        end
        if (wr_remain)
        begin
            st_next.remaining_toggle = reg_wdata[`FT_TOGGLE_POS];
            st_next.remaining = reg_wdata[`FT_COUNT_MSB:0];
        end
        if (wr_cmd && reg_wdata[`FT_RESET_POS])
        begin
            st_next.interval = `FT_INTERVAL_NOMINAL;
            st_next.budget = `FT_BUDGET_RESET;
            st_next.interval_toggle = 1'b0;
            st_next.run = 1'b0;
        end

        // sticky status: read clears, a new event wins over the clear
        st_next.irq_status = (rd_istat ? 2'h0 : st_reg.irq_status) | events;

        // read data for the next cycle
        st_next.rdata = '0;
        if (reg_rd)
        begin
            case (reg_addr)
                `FT_CODE_CTRL:
                    st_next.rdata[`FT_RUN_POS] = st_reg.run;
                `FT_CODE_ISTAT:
                    st_next.rdata[`FT_IRQ_W-1:0] = st_reg.irq_status;
                `FT_CODE_IMASK:
                    st_next.rdata[`FT_IRQ_W-1:0] = st_reg.irq_mask;
                `FT_CODE_INTERVAL:
                begin
                    st_next.rdata[`FT_TOGGLE_POS] = st_reg.interval_toggle;
                    st_next.rdata[`FT_BUDGET_MSB:`FT_BUDGET_LSB] = st_reg.budget;
                    st_next.rdata[`FT_COUNT_MSB:0] = st_reg.interval;
                end
                `FT_CODE_REMAIN:
                begin
                    st_next.rdata[`FT_TOGGLE_POS] = st_reg.remaining_toggle;
                    st_next.rdata[`FT_COUNT_MSB:0] = st_reg.remaining;
                end
                `FT_CODE_NUMBER:
                    st_next.rdata[`FT_NUMBER_MSB:0] = st_reg.frame_num;
                default:
                    st_next.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st_reg <= '0;
            st_reg.interval <= `FT_INTERVAL_NOMINAL;
            st_reg.remaining <= `FT_REMAIN_RESET;
            st_reg.frame_num <= `FT_NUMBER_RESET;
            st_reg.phase <= frame_timer_pkg::PH_IDLE;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign reg_rdata = st_reg.rdata;
    assign irq = |(st_reg.irq_status & st_reg.irq_mask);
    assign sof_pulse = st_reg.sof;
    assign comm_wr = st_reg.comm_wr;
    assign comm_data = st_reg.frame_num;
    assign ed_fetch_ok = st_reg.run && (st_reg.phase == frame_timer_pkg::PH_IDLE
                                        || st_reg.phase == frame_timer_pkg::PH_FLAG);
    assign operational_state = st_reg.run;
    assign remaining_count = st_reg.remaining;
    assign frame_number = st_reg.frame_num;
    assign packet_count = st_reg.packet_count;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_frame_start;
        sof_pulse && !reload && !entry;
    endsequence

    sequence s_comm_then_flag;
        comm_wr ##1 st_reg.irq_status[`FT_IRQ_SOF_POS];
    endsequence

    AST_DECREMENT: assert property (
        st_reg.run && !entry && tick && st_reg.remaining != '0 && !wr_remain
        |=> remaining_count == $past(remaining_count) - 14'h0001)
        else $error("remaining counter did not decrement on bit tick");

    AST_RELOAD: assert property (
        reload && !wr_remain && !wr_interval && !wr_cmd
        |=> remaining_count == $past(st_reg.interval))
        else $error("remaining counter not reloaded from interval");

    AST_TOGGLE_COPY: assert property (
        reload && !wr_remain && !wr_interval && !wr_cmd
        |=> st_reg.remaining_toggle == $past(st_reg.interval_toggle))
        else $error("remaining toggle not copied at frame boundary");

    AST_NUMBER_INC: assert property (
        reload |=> frame_number == $past(frame_number) + 16'h0001)
        else $error("frame number did not advance on reload");

    AST_BUDGET_LOAD: assert property (
        reload && !wr_interval && !wr_cmd |=> packet_count == $past(st_reg.budget))
        else $error("packet counter not loaded at frame start");

    AST_NOMINAL: assert property (
        wr_cmd && reg_wdata[`FT_RESET_POS] |=> st_reg.interval == `FT_INTERVAL_NOMINAL && !operational_state)
        else $error("controller reset did not restore nominal interval");

    AST_HOLD: assert property (
        !st_reg.run && !wr_remain |=> $stable(remaining_count) && $stable(frame_number))
        else $error("counters moved outside operational state");

    AST_ENTRY: assert property (
        entry && !wr_remain |=> remaining_count == $past(st_reg.interval) ##1 comm_wr)
        else $error("entry did not reload remaining counter");

    AST_START_SEQ: assert property (
        s_frame_start |-> !ed_fetch_ok ##1 s_comm_then_flag)
        else $error("frame start sequence out of order");

    AST_READ_NUMBER: assert property (
        rd_hit(reg_rd, reg_addr, `FT_CODE_NUMBER)
        |=> reg_rdata == {16'h0000, $past(frame_number)})
        else $error("frame number read returned wrong value");

    AST_TICK_GAP: assert property (
        tick |=> !tick)
        else $error("bit tick longer than one cycle");

    AST_BUDGET_DRAIN: assert property (
        st_reg.run && !entry && !reload && tick && packet_bit && packet_count != '0
        |=> packet_count == $past(packet_count) - 15'h0001)
        else $error("packet counter did not count a consumed bit");

    AST_INTERVAL_WRITE: assert property (
        wr_interval |=> st_reg.interval == $past(reg_wdata[`FT_COUNT_MSB:0]))
        else $error("interval write did not land");

    AST_RDATA_IDLE: assert property (
        !reg_rd |=> reg_rdata == '0)
        else $error("read data not zero outside the read answer");

    AST_COMM_AFTER_SOF: assert property (
        comm_wr |-> $past(sof_pulse))
        else $error("shared area write not one cycle after frame start");

    AST_FLAG_STICKY: assert property (
        events[`FT_IRQ_SOF_POS] |=> st_reg.irq_status[`FT_IRQ_SOF_POS])
        else $error("frame start flag lost against a status read");

    AST_READ_CLEAR: assert property (
        rd_istat && events == '0 |=> st_reg.irq_status == '0)
        else $error("status read did not clear the flags");

endmodule

`default_nettype wire

// [sim/frame_sched_model.sv]
// scheduler model: consumes packet bits and watches the frame start order
`timescale 1ns/10ps
`default_nettype none

module frame_sched_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sof_pulse,
    input wire logic comm_wr,
    input wire logic ed_fetch_ok,
    output logic packet_bit,
    output logic fault
);
    logic sof_d;
    logic [2:0] cnt;

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            sof_d <= 1'b0;
            cnt <= 3'h0;
            fault <= 1'b0;
        end
        else
        begin
            sof_d <= sof_pulse;
            cnt <= cnt + 3'h1;
            if ((sof_pulse || comm_wr) && ed_fetch_ok)
                fault <= 1'b1;
            if (sof_d !== comm_wr)
                fault <= 1'b1;
        end
    end

    // consumes in bursts, pausing one cycle in eight to act slowly
    assign packet_bit = ed_fetch_ok && (cnt != 3'h7);
endmodule
`default_nettype wire

// [sim/test_usb_host_frame_timer.sv]
// self-checking bench of the frame timer
`timescale 1ns/10ps
`default_nettype none

module test_usb_host_frame_timer;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic irq, packet_bit, sof_pulse, comm_wr, ed_fetch_ok, operational_state, fault;
    logic [15:0] comm_data, frame_number;
    logic [13:0] remaining_count, held;
    logic [14:0] packet_count, budget;
    logic [31:0] seed = 32'h000017E8;
    logic [31:0] saved;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic rd_seen = 1'b0;
    logic [15:0] exp_num = 16'h0000;
    logic [31:0] frame_ext = 32'h00000000;
    int n_mismatch = 0;
    int n_tests = 0;
    int gap = 0;
    int n_sof = 0;
    int cycles = 0;

    always #12.5 ref_clk = ~ref_clk;

    usb_host_frame_timer dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .packet_bit(packet_bit),
        .sof_pulse(sof_pulse), .comm_wr(comm_wr), .comm_data(comm_data), .ed_fetch_ok(ed_fetch_ok),
        .operational_state(operational_state), .remaining_count(remaining_count),
        .frame_number(frame_number), .packet_count(packet_count));

    frame_sched_model sched (.ref_clk(ref_clk), .rst(rst), .sof_pulse(sof_pulse), .comm_wr(comm_wr),
        .ed_fetch_ok(ed_fetch_ok), .packet_bit(packet_bit), .fault(fault));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        n_tests++;
        if ((got & m) !== (exp & m))
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got & m, exp & m);
        end
    endtask

    task automatic wr(input logic [7:0] code, input logic [31:0] data);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= code;
        reg_wdata <= data;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] code, input logic [31:0] exp, input logic [31:0] m);
        exp_q.push_back(exp);
        msk_q.push_back(m);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= code;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // watcher: read data the cycle after a strobe, frame events as they appear
    always @(posedge ref_clk)
        rd_seen <= reg_rd;

    always @(negedge ref_clk)
    begin
        gap++;
        if (rd_seen)
            cmp(reg_rdata, exp_q.pop_front(), msk_q.pop_front());
        if (sof_pulse)
        begin
            exp_num++;
            n_sof++;
            cmp({16'h0000, frame_number}, {16'h0000, exp_num}, 32'h0000FFFF);
            // software-style extension of the 16-bit number to a 32-bit count
            frame_ext = frame_ext + {16'h0000, frame_number - frame_ext[15:0]};
            cmp(frame_ext, n_sof, 32'hFFFFFFFF);
            cmp({17'h00000, packet_count}, {17'h00000, budget}, 32'h00007FFF);
            if (n_sof > 2)
                cmp(gap, 32'h00000014, 32'hFFFFFFFF);
            gap = 0;
        end
        if (comm_wr)
            cmp({16'h0000, comm_data}, {16'h0000, exp_num}, 32'h0000FFFF);
    end

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        budget = 15'h0000;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(8'h0D, 32'h00002EDF, 32'hFFFFFFFF);
        rd(8'h0E, 32'h00000000, 32'hFFFFFFFF);
        rd(8'h0F, 32'h00000000, 32'hFFFFFFFF);
        rd(8'h55, 32'h00000000, 32'hFFFFFFFF);
        $display("reset values done");
        seed = xs(seed);
        budget = seed[14:0];
        saved = {1'b1, budget, 16'h0005};
        wr(8'h8D, saved);
        rd(8'h0D, saved, 32'hFFFFFFFF);
        wr(8'h81, 32'h00000001);
        for (int i = 0; i < 300 && n_sof < 4; i++)
            @(posedge ref_clk);
        @(negedge ref_clk);
        cmp({31'h0, irq}, 32'h00000000, 32'h00000001);
        cmp({31'h0, operational_state}, 32'h00000001, 32'h00000001);
        wr(8'h84, 32'h00000001);
        @(negedge ref_clk);
        cmp({31'h0, irq}, 32'h00000001, 32'h00000001);
        rd(8'h0E, 32'h80000000, 32'h80000000);
        $display("frame run done");
        wr(8'h81, 32'h00000000);
        @(negedge ref_clk);
        held = remaining_count;
        repeat (30) @(posedge ref_clk);
        @(negedge ref_clk);
        cmp({18'h0, remaining_count}, {18'h0, held}, 32'h00003FFF);
        rd(8'h03, 32'h00000001, 32'h00000001);
        rd(8'h03, 32'h00000000, 32'h00000003);
        @(negedge ref_clk);
        cmp({31'h0, irq}, 32'h00000000, 32'h00000001);
        wr(8'h8F, 32'h00001234);
        rd(8'h0F, {16'h0000, exp_num}, 32'hFFFFFFFF);
        $display("hold and status done");
        rd(8'h0D, saved, 32'hFFFFFFFF);
        wr(8'h82, 32'h00000001);
        rd(8'h0D, 32'h00002EDF, 32'hFFFFFFFF);
        rd(8'h01, 32'h00000000, 32'h00000001);
        wr(8'h8D, saved);
        rd(8'h0D, saved, 32'hFFFFFFFF);
        wr(8'h8E, 32'h80000123);
        rd(8'h0E, 32'h80000123, 32'h80003FFF);
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        cmp({31'h0, fault}, 32'h00000000, 32'h00000001);
        $display("controller reset done");
        close_out();
    end
endmodule
`default_nettype wire
